// >>> hdl/boot_self_test_control.v
`timescale 1ns/1ps
`include "self_test_defs.vh"
module boot_self_test_control #(
   parameter LOGIC_N = 8,
   parameter MEM_W = 32,
   parameter STEP_TIMEOUT_CYC = `STEP_TIMEOUT_US * `CLK_MHZ
) (
   input wire core_clk,
   input wire rst_b,
   input wire logic_test_enable,
   input wire mem_test_enable,
   input wire run_mem_test_req,
   input wire [LOGIC_N-1:0] logic_done,
   input wire [LOGIC_N-1:0] logic_fail,
   input wire [3*MEM_W-1:0] mem_done,
   input wire [3*MEM_W-1:0] mem_fail,
   input wire mem_uncorrectable,
   output reg logic_test_start,
   output reg mem_test_start,
   output reg hold_device_reset,
   output reg device_halt,
   output reg sw_reset_req,
   output reg [LOGIC_N-1:0] logic_test_fail_status,
   output reg [LOGIC_N-1:0] logic_test_unfinished_status,
   output reg [MEM_W-1:0] mem_test_fail_low,
   output reg [MEM_W-1:0] mem_test_fail_mid,
   output reg [MEM_W-1:0] mem_test_fail_high,
   output reg [MEM_W-1:0] mem_test_unfinished_low,
   output reg [MEM_W-1:0] mem_test_unfinished_mid,
   output reg [MEM_W-1:0] mem_test_unfinished_high,
   output reg [`ERR_W-1:0] self_test_internal_error
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam SYNC_W = 4 + LOGIC_N * 2 + MEM_W * 6;
   wire [SYNC_W-1:0] raw_in;
   reg [SYNC_W-1:0] sync1_r;
   reg [SYNC_W-1:0] sync2_r;
   assign raw_in = {logic_test_enable, mem_test_enable, run_mem_test_req, mem_uncorrectable,
                    logic_done, logic_fail, mem_done, mem_fail};
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= {SYNC_W{1'b0}};
         sync2_r <= {SYNC_W{1'b0}};
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end
   wire s_logic_en = sync2_r[SYNC_W-1];
   wire s_mem_en = sync2_r[SYNC_W-2];
   wire s_mem_req = sync2_r[SYNC_W-3];
   wire s_uncorr = sync2_r[SYNC_W-4];
   wire [LOGIC_N-1:0] s_ldone = sync2_r[MEM_W*6+LOGIC_N*2-1:MEM_W*6+LOGIC_N];
   wire [LOGIC_N-1:0] s_lfail = sync2_r[MEM_W*6+LOGIC_N-1:MEM_W*6];
   wire [3*MEM_W-1:0] s_mdone = sync2_r[MEM_W*6-1:MEM_W*3];
   wire [3*MEM_W-1:0] s_mfail = sync2_r[MEM_W*3-1:0];
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [31:0] timer_r;
   reg [3:0] pulse_r;
   reg boot_r;
   reg req_d_r;
   reg s_uncorr_r;
   reg [1:0] settle_r;
   wire req_rise = s_mem_req & ~req_d_r;
   wire timeout = (timer_r >= STEP_TIMEOUT_CYC - 1);
   wire logic_all = &s_ldone;
   wire mem_all = &s_mdone;
   wire logic_bad = |logic_test_fail_status | |logic_test_unfinished_status;
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `ST_IDLE: begin
            // synchronisers still filling after release
            if (settle_r != `SYNC_SETTLE_CYC)
               state_nxt = `ST_IDLE;
            else if (s_logic_en)
               state_nxt = `ST_LOGIC;
            else if (s_mem_en)
               state_nxt = `ST_MEM;
            else
               state_nxt = `ST_EVAL;
         end
         `ST_LOGIC: begin
            if (logic_all || timeout)
               state_nxt = s_mem_en ? `ST_MEM : `ST_EVAL;
         end
         `ST_MEM: begin
            if (mem_all || timeout)
               state_nxt = boot_r ? `ST_EVAL : `ST_RESET;
         end
         `ST_EVAL: begin
            if (logic_bad || s_uncorr_r)
               state_nxt = `ST_HALT;
            else
               state_nxt = `ST_RUN;
         end
         `ST_RUN: begin
            if (req_rise)
               state_nxt = `ST_MEM;
         end
         `ST_HALT: state_nxt = `ST_HALT;
         `ST_RESET: begin
            if (pulse_r == 4'h0)
               state_nxt = `ST_RUN;
         end
         default: state_nxt = `ST_HALT;
      endcase
   end
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= `ST_IDLE;
         settle_r <= 2'h0;
         timer_r <= 32'h0;
         pulse_r <= 4'h0;
         boot_r <= 1'b1;
         req_d_r <= 1'b0;
         s_uncorr_r <= 1'b0;
         logic_test_start <= 1'b0;
         mem_test_start <= 1'b0;
         hold_device_reset <= 1'b1;
         device_halt <= 1'b0;
         sw_reset_req <= 1'b0;
         logic_test_fail_status <= {LOGIC_N{1'b0}};
         logic_test_unfinished_status <= {LOGIC_N{1'b0}};
         mem_test_fail_low <= {MEM_W{1'b0}};
         mem_test_fail_mid <= {MEM_W{1'b0}};
         mem_test_fail_high <= {MEM_W{1'b0}};
         mem_test_unfinished_low <= {MEM_W{1'b0}};
         mem_test_unfinished_mid <= {MEM_W{1'b0}};
         mem_test_unfinished_high <= {MEM_W{1'b0}};
         self_test_internal_error <= {`ERR_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         if (state_r == `ST_IDLE && settle_r != `SYNC_SETTLE_CYC)
            settle_r <= settle_r + 2'h1;
         req_d_r <= s_mem_req;
         timer_r <= (state_nxt != state_r) ? 32'h0 : timer_r + 32'h1;
         logic_test_start <= (state_nxt == `ST_LOGIC);
         mem_test_start <= (state_nxt == `ST_MEM);
         // keep device in reset until boot evaluation finds no logic fault and no uncorrectable memory error
         hold_device_reset <= boot_r & (state_nxt != `ST_RUN);
         device_halt <= (state_nxt == `ST_HALT);
         sw_reset_req <= (state_nxt == `ST_RESET);
         if (state_r == `ST_RUN)
            boot_r <= 1'b0;
         if (state_nxt == `ST_RESET && state_r != `ST_RESET)
            pulse_r <= `RESET_PULSE_CYC - 4'h1;
         else if (pulse_r != 4'h0)
            pulse_r <= pulse_r - 4'h1;
         // results captured at end of each step, held otherwise
         if (state_r == `ST_LOGIC && state_nxt != `ST_LOGIC) begin
            logic_test_fail_status <= s_lfail;
            logic_test_unfinished_status <= ~s_ldone;
         end
         if (state_r == `ST_MEM && state_nxt != `ST_MEM) begin
            s_uncorr_r <= s_uncorr;
            mem_test_fail_low <= s_mfail[MEM_W-1:0];
            mem_test_fail_mid <= s_mfail[2*MEM_W-1:MEM_W];
            mem_test_fail_high <= s_mfail[3*MEM_W-1:2*MEM_W];
            mem_test_unfinished_low <= ~s_mdone[MEM_W-1:0];
            mem_test_unfinished_mid <= ~s_mdone[2*MEM_W-1:MEM_W];
            mem_test_unfinished_high <= ~s_mdone[3*MEM_W-1:2*MEM_W];
         end
         if (state_r == `ST_LOGIC && timeout && !logic_all)
            self_test_internal_error[`ERR_LOGIC_TIMEOUT] <= 1'b1;
         if (state_r == `ST_MEM && timeout && !mem_all)
            self_test_internal_error[`ERR_MEM_TIMEOUT] <= 1'b1;
         if (state_r > `ST_RESET)
            self_test_internal_error[`ERR_BAD_STATE] <= 1'b1;
      end
   end
endmodule // boot_self_test_control

// >>> hdl/self_test_defs.vh
`ifndef SELF_TEST_DEFS_VH
`define SELF_TEST_DEFS_VH
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define ST_IDLE 3'h0
`define ST_LOGIC 3'h1
`define ST_MEM 3'h2
`define ST_EVAL 3'h3
`define ST_RUN 3'h4
`define ST_HALT 3'h5
`define ST_RESET 3'h6
// ----------------------------------------
// internal error bits
// ----------------------------------------
`define ERR_LOGIC_TIMEOUT 0
`define ERR_MEM_TIMEOUT 1
`define ERR_BAD_STATE 2
`define ERR_W 3
// ----------------------------------------
// watchdog, reset pulse and synchroniser settle lengths
// ----------------------------------------
`define STEP_TIMEOUT_US 100
`define CLK_MHZ 40
`define RESET_PULSE_CYC 4'h8
`define SYNC_SETTLE_CYC 2'h2
`endif

// >>> verif/boot_self_test_asserts.sv
`timescale 1ns/1ps
module boot_self_test_asserts #(parameter LOGIC_N = 8) (
   input wire core_clk,
   input wire rst_b,
   input wire logic_test_start,
   input wire mem_test_start,
   input wire hold_device_reset,
   input wire device_halt,
   input wire sw_reset_req,
   input wire [LOGIC_N-1:0] logic_test_fail_status,
   input wire [LOGIC_N-1:0] logic_test_unfinished_status,
   input wire [2:0] self_test_internal_error
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_halt_sticky:
      assert property (device_halt |=> device_halt) else $error("halt dropped");
   a_halt_in_reset:
      assert property (device_halt |-> hold_device_reset) else $error("halt left reset");
   a_step_exclusive:
      assert property (!(logic_test_start && mem_test_start)) else $error("steps overlap");
   a_release_idle:
      assert property ($fell(hold_device_reset) |-> !logic_test_start && !mem_test_start
         && !device_halt) else $error("release while busy");
   a_release_clean:
      assert property ($fell(hold_device_reset) |-> logic_test_fail_status == 0
         && logic_test_unfinished_status == 0) else $error("release after logic fault");
   a_logic_hold:
      assert property ((!logic_test_start)[*3] |-> $stable(logic_test_fail_status)
         && $stable(logic_test_unfinished_status)) else $error("logic status changed");
   a_err_sticky:
      assert property ((~self_test_internal_error & $past(self_test_internal_error)) == 3'h0)
         else $error("error bit cleared");
   a_swreset_len:
      assert property ($rose(sw_reset_req) |-> sw_reset_req[*8] ##1 !sw_reset_req)
         else $error("reset request length");
   cover property ($fell(hold_device_reset));
   cover property ($rose(device_halt));
   cover property ($rose(sw_reset_req));
endmodule // boot_self_test_asserts
bind boot_self_test_control boot_self_test_asserts #(.LOGIC_N(LOGIC_N)) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .logic_test_start(logic_test_start),
   .mem_test_start(mem_test_start), .hold_device_reset(hold_device_reset),
   .device_halt(device_halt), .sw_reset_req(sw_reset_req),
   .logic_test_fail_status(logic_test_fail_status),
   .logic_test_unfinished_status(logic_test_unfinished_status),
   .self_test_internal_error(self_test_internal_error));

// >>> verif/test_boot_self_test_control.sv
`timescale 1ns/1ps
module test_boot_self_test_control;
   reg core_clk = 1'b0;
   reg rst_b = 1'b0;
   reg en = 1'b1;
   reg req = 1'b0;
   reg unc = 1'b0;
   reg [7:0] ld = 8'hFF;
   reg [7:0] lf = 8'h00;
   reg [95:0] mf = 96'h0;
   wire hold, halt, srr;
   wire [7:0] lfs, lus;
   wire [31:0] mfl, mfm, mfh, mul;
   wire [2:0] err;
   integer fails = 0;
   integer n_checks = 0;
   integer i;
   boot_self_test_control #(.STEP_TIMEOUT_CYC(50)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
      .logic_test_enable(en), .mem_test_enable(en), .run_mem_test_req(req), .logic_done(ld),
      .logic_fail(lf), .mem_done({96{1'b1}}), .mem_fail(mf), .mem_uncorrectable(unc),
      .logic_test_start(), .mem_test_start(), .hold_device_reset(hold), .device_halt(halt),
      .sw_reset_req(srr), .logic_test_fail_status(lfs), .logic_test_unfinished_status(lus),
      .mem_test_fail_low(mfl), .mem_test_fail_mid(mfm), .mem_test_fail_high(mfh),
      .mem_test_unfinished_low(mul), .mem_test_unfinished_mid(), .mem_test_unfinished_high(),
      .self_test_internal_error(err));
   initial forever #12.5 core_clk = ~core_clk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input string nm, input [95:0] seen, input [95:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // reset held 20 cycles, then wait for release or halt
   task boot(input [7:0] lfv, input [7:0] ldv, input [95:0] mfv, input uv, input env);
      begin
         rst_b <= 1'b0;
         lf <= lfv;
         ld <= ldv;
         mf <= mfv;
         unc <= uv;
         en <= env;
         repeat (20) @(posedge core_clk);
         rst_b <= 1'b1;
         for (i = 0; i < 400 && hold === 1'b1 && halt !== 1'b1; i = i + 1) @(negedge core_clk);
         repeat (3) @(posedge core_clk);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      #1000000;
      fails = fails + 1;
      final_report;
   end
   initial begin
      boot(8'h00, 8'hFF, 96'h0, 1'b0, 1'b1);
      chk("hold", hold, 1'b0);
      chk("mul", mul, 32'h0);
      chk("halt", halt, 1'b0);
      lf <= 8'hFF;
      req <= 1'b1;
      for (i = 0; i < 200 && srr !== 1'b1; i = i + 1) @(negedge core_clk);
      chk("reset_req", srr, 1'b1);
      chk("lfs_held", lfs, 8'h00);
      @(posedge core_clk);
      req <= 1'b0;
      boot(8'h08, 8'hFF, 96'h0, 1'b0, 1'b1);
      chk("halt", halt, 1'b1);
      chk("lfs", lfs, 8'h08);
      boot(8'h00, 8'hFE, 96'h0, 1'b0, 1'b1);
      chk("lus", lus, 8'h01);
      chk("err", err, 3'h1);
      boot(8'h00, 8'hFF, 96'h10000000000, 1'b0, 1'b1);
      chk("halt", halt, 1'b0);
      chk("mfm", mfm, 32'h100);
      chk("mfh", mfh, 32'h0);
      boot(8'h00, 8'hFF, 96'h1, 1'b1, 1'b1);
      chk("halt", halt, 1'b1);
      chk("mfl", mfl, 32'h1);
      boot(8'hFF, 8'h00, 96'h0, 1'b0, 1'b0);
      chk("hold", hold, 1'b0);
      chk("lus", lus, 8'h00);
      final_report;
   end
endmodule // test_boot_self_test_control
